//--- core/spimm_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "spimm_defines.svh"
module spimm_host (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial pins
	output spimm_pkg::spimm_pins_s pins_o,
	input wire logic mosi_i,
	input wire logic miso_i
);
	import spimm_pkg::*;

	// ************************************************************
	// Registers
	// ************************************************************
	logic [8:0] ctrl_ff;
	logic [7:0] txd_ff, rxd_ff, sstat_ff;
	logic busy_ff, done_ff, flag_ff, ack_ff;
	logic [1:0] mosi_sync_ff, miso_sync_ff;
	logic go_pulse;
	spimm_mode_e mode;

	typedef enum logic [2:0] {
		SPIMM_IDLE = 3'b000,
		SPIMM_CMD = 3'b001,
		SPIMM_STS = 3'b010,
		SPIMM_DAT = 3'b011,
		SPIMM_LBIT = 3'b100,
		SPIMM_GAP = 3'b101
	} spimm_state_e;
	spimm_state_e st_ff;
	logic [3:0] bit_ff;
	logic [7:0] sh_ff;
	logic sel_ff, oe_ff, dout_ff, run;
	logic rise, fall, sclk;

	// ************************************************************
	// Bus decode
	// ************************************************************
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr_ctrl = wb_req && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == `SPIMM_REG_CTRL;
	wire wr_txd = wb_req && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == `SPIMM_REG_TXD;
	assign go_pulse = wr_ctrl && wb_dat_i[`SPIMM_CTRL_GO] && !busy_ff;
	assign mode = spimm_mode_e'(ctrl_ff[`SPIMM_CTRL_MODE_HI:`SPIMM_CTRL_MODE_LO]);
	wire dir_rd = ctrl_ff[`SPIMM_CTRL_DIR];
	wire tgt = ctrl_ff[`SPIMM_CTRL_TGT];
	wire last = ctrl_ff[`SPIMM_CTRL_LAST];
	wire [31:0] stat_word = {16'h0000, sstat_ff, 5'h00, flag_ff, done_ff,
		busy_ff};
	wire [31:0] rd_mux =
		(wb_adr_i == `SPIMM_REG_CTRL) ? {23'h000000, ctrl_ff} :
		(wb_adr_i == `SPIMM_REG_STAT) ? stat_word :
		(wb_adr_i == `SPIMM_REG_TXD) ? {24'h000000, txd_ff} :
		(wb_adr_i == `SPIMM_REG_RXD) ? {24'h000000, rxd_ff} : 32'h00000000;

	// Ack one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			ack_ff <= wb_req;
			wb_dat_o <= rd_mux;
		end
	end
	assign wb_ack_o = ack_ff;

	// Control word, writable only while idle except for the last-byte bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= 9'h000;
			txd_ff <= `SPIMM_ZERO8;
		end else begin
			if (wr_ctrl && !busy_ff)
				ctrl_ff <= {wb_dat_i[8:1], 1'b0};
			else if (wr_ctrl)
				ctrl_ff[`SPIMM_CTRL_LAST] <= wb_dat_i[`SPIMM_CTRL_LAST];
			if (wr_txd)
				txd_ff <= wb_dat_i[7:0];
		end
	end

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mosi_sync_ff <= 2'b00;
			miso_sync_ff <= 2'b00;
		end else begin
			mosi_sync_ff <= {mosi_sync_ff[0], mosi_i};
			miso_sync_ff <= {miso_sync_ff[0], miso_i};
		end
	end
	wire mosi_s = mosi_sync_ff[1];
	wire miso_s = miso_sync_ff[1];

	spimm_clkgen u_clk (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(run),
		.rise_o(rise),
		.fall_o(fall),
		.sclk_o(sclk)
	);

	// ************************************************************
	// Frame sequencer
	// ************************************************************
	// Clock runs only inside the bit phases; the gap holds select idle
	assign run = (st_ff != SPIMM_IDLE) && (st_ff != SPIMM_GAP);
	// Legacy data travels on the rising edge, other modes sample on the
	// rising edge too (mode 0 style: launch on falling, capture on rising)
	wire sample = rise;
	wire launch = (mode == SPIMM_LEG) ? rise : fall;
	// Returned status: half duplex status comes on MISO (4-pin) or MOSI
	wire sts_in = (mode == SPIMM_HD3) ? mosi_s : miso_s;
	wire dat_in = (mode == SPIMM_HD4 || mode == SPIMM_HD3) ? mosi_s : miso_s;
	wire room = !sh_ff[`SPIMM_HD_RXF_BIT] && sh_ff[`SPIMM_HD_ACK_BIT];
	wire [7:0] cmd_byte = {ctrl_ff[`SPIMM_CTRL_ADDR_HI:`SPIMM_CTRL_ADDR_LO],
		dir_rd, 4'h0};
	wire leg_bad = !dir_rd && tgt;
	wire hd4_wr = (mode == SPIMM_HD4) && !dir_rd;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= SPIMM_IDLE;
			bit_ff <= 4'h0;
			sh_ff <= `SPIMM_ZERO8;
			sel_ff <= 1'b0;
			oe_ff <= 1'b0;
			dout_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			flag_ff <= 1'b0;
			rxd_ff <= `SPIMM_ZERO8;
			sstat_ff <= `SPIMM_ZERO8;
		end else begin
			unique case (st_ff)
			SPIMM_IDLE: begin
				if (go_pulse) begin
					busy_ff <= 1'b1;
					done_ff <= 1'b0;
					flag_ff <= 1'b0;
					sel_ff <= 1'b1;
					oe_ff <= 1'b1;
					bit_ff <= 4'h0;
					if (wb_dat_i[`SPIMM_CTRL_MODE_HI:`SPIMM_CTRL_MODE_LO]
						== SPIMM_LEG) begin
						st_ff <= SPIMM_CMD;
						// Start bit first, then direction and target
						sh_ff <= {1'b1, wb_dat_i[`SPIMM_CTRL_DIR],
							wb_dat_i[`SPIMM_CTRL_TGT], 5'h00};
						dout_ff <= 1'b1;
					end else if (wb_dat_i[`SPIMM_CTRL_MODE_HI:
						`SPIMM_CTRL_MODE_LO] == SPIMM_UNM) begin
						st_ff <= SPIMM_DAT;
						sh_ff <= txd_ff;
						dout_ff <= txd_ff[7];
					end else begin
						st_ff <= SPIMM_CMD;
						sh_ff <= {wb_dat_i[7:5], wb_dat_i[3], 4'h0};
						dout_ff <= wb_dat_i[7];
					end
				end
			end
			SPIMM_CMD: begin
				if (mode == SPIMM_LEG) begin
					if (rise) begin
						bit_ff <= bit_ff + 4'h1;
						if (bit_ff == `SPIMM_LEG_SETUP - 4'h1) begin
							st_ff <= SPIMM_DAT;
							bit_ff <= 4'h0;
							sh_ff <= txd_ff;
							// Reads and status reads leave MOSI low
							dout_ff <= dir_rd ? 1'b0 : txd_ff[7];
						end else begin
							sh_ff <= {sh_ff[6:0], 1'b0};
							dout_ff <= sh_ff[6];
						end
					end
				end else begin
					if (sample)
						bit_ff <= bit_ff + 4'h1;
					if (sample && mode == SPIMM_HD4)
						sh_ff <= {sh_ff[6:0], sts_in};
					if (launch && bit_ff != `SPIMM_BITS)
						dout_ff <= cmd_byte[3'(7 - bit_ff)];
					if (launch && bit_ff == `SPIMM_BITS) begin
						bit_ff <= 4'h0;
						// Let go of MOSI before the slave answers, except on 4-pin writes
						oe_ff <= (mode == SPIMM_HD4) && !dir_rd;
						st_ff <= (mode == SPIMM_HD3) ? SPIMM_STS
							: (dir_rd ? SPIMM_DAT : SPIMM_LBIT);
					end
				end
			end
			SPIMM_LBIT: begin
				// 4-pin write decision on the command-phase status
				sstat_ff <= sh_ff;
				if (room) begin
					st_ff <= SPIMM_DAT;
					oe_ff <= 1'b1;
					sh_ff <= txd_ff;
					dout_ff <= txd_ff[7];
				end else begin
					flag_ff <= 1'b1;
					st_ff <= SPIMM_GAP;
					sel_ff <= 1'b0;
				end
			end
			SPIMM_STS: begin
				// 3-pin status byte arrives on the shared line
				if (sample) begin
					sh_ff <= {sh_ff[6:0], sts_in};
					bit_ff <= bit_ff + 4'h1;
				end
				if (launch && bit_ff == `SPIMM_BITS) begin
					bit_ff <= 4'h0;
					sstat_ff <= sh_ff;
					if (dir_rd) begin
						st_ff <= SPIMM_DAT;
					end else if (room && !done_ff) begin
						st_ff <= SPIMM_DAT;
						oe_ff <= 1'b1;
						sh_ff <= txd_ff;
						dout_ff <= txd_ff[7];
					end else begin
						flag_ff <= !room;
						st_ff <= SPIMM_GAP;
						sel_ff <= 1'b0;
					end
				end
			end
			SPIMM_DAT: begin
				if (mode == SPIMM_LEG) begin
					// Ninth bit after the byte is the status bit
					if (rise) begin
						bit_ff <= bit_ff + 4'h1;
						if (bit_ff < `SPIMM_BITS) begin
							sh_ff <= {sh_ff[6:0], miso_s};
							dout_ff <= dir_rd ? 1'b0 : sh_ff[6];
						end else begin
							flag_ff <= miso_s;
							rxd_ff <= sh_ff;
							done_ff <= 1'b1;
							st_ff <= SPIMM_GAP;
							bit_ff <= 4'h0;
							sel_ff <= 1'b0;
							dout_ff <= 1'b0;
						end
					end
				end else begin
					if (sample) begin
						bit_ff <= bit_ff + 4'h1;
						sh_ff <= {sh_ff[6:0], oe_ff ? miso_s : dat_in};
					end
					if (launch && bit_ff != `SPIMM_BITS)
						dout_ff <= sh_ff[7];
					if (launch && bit_ff == `SPIMM_BITS) begin
						bit_ff <= 4'h0;
						rxd_ff <= sh_ff;
						done_ff <= 1'b1;
						if (mode == SPIMM_UNM || last) begin
							st_ff <= SPIMM_GAP;
							sel_ff <= 1'b0;
							oe_ff <= 1'b0;
						end else if (mode == SPIMM_HD3 && !dir_rd) begin
							done_ff <= 1'b0;
							oe_ff <= 1'b0;
							st_ff <= SPIMM_STS;
						end else if (hd4_wr && room) begin
							// Status shifted in on MISO during this byte
							done_ff <= 1'b0;
							sstat_ff <= sh_ff;
							sh_ff <= txd_ff;
							dout_ff <= txd_ff[7];
						end else if (hd4_wr) begin
							// No room left: stop the stream, not overrun
							flag_ff <= 1'b1;
							st_ff <= SPIMM_GAP;
							sel_ff <= 1'b0;
							oe_ff <= 1'b0;
						end
					end
				end
				// Legacy target-one write carries no data effect
				if (mode == SPIMM_LEG && leg_bad)
					flag_ff <= 1'b1;
			end
			SPIMM_GAP: begin
				// Select deasserted for a full serial period before next frame
				oe_ff <= 1'b0;
				bit_ff <= bit_ff + 4'h1;
				if (bit_ff == `SPIMM_BITS) begin
					st_ff <= SPIMM_IDLE;
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
			end
			default: st_ff <= SPIMM_IDLE;
			endcase
		end
	end

	// Pin outputs; select polarity follows the selected mode
	assign pins_o.sclk = sclk;
	assign pins_o.sel = (mode == SPIMM_LEG) ? sel_ff : !sel_ff;
	assign pins_o.mosi_o = dout_ff;
	assign pins_o.mosi_oe = oe_ff && (mode != SPIMM_UNM || sel_ff);
endmodule
`default_nettype wire

//--- core/spimm_defines.svh
`ifndef SPIMM_DEFINES_SVH
`define SPIMM_DEFINES_SVH

// Register offsets (byte addresses on the Wishbone slave)
`define SPIMM_REG_CTRL 4'h0
`define SPIMM_REG_STAT 4'h4
`define SPIMM_REG_TXD 4'h8
`define SPIMM_REG_RXD 4'hC

// Control register fields
`define SPIMM_CTRL_GO 0
`define SPIMM_CTRL_MODE_LO 1
`define SPIMM_CTRL_MODE_HI 2
`define SPIMM_CTRL_DIR 3
`define SPIMM_CTRL_TGT 4
`define SPIMM_CTRL_ADDR_LO 5
`define SPIMM_CTRL_ADDR_HI 7
`define SPIMM_CTRL_LAST 8

// Status register fields
`define SPIMM_STAT_BUSY 0
`define SPIMM_STAT_DONE 1
`define SPIMM_STAT_FLAG 2
`define SPIMM_STAT_SSTAT_LO 8

// Half-duplex status byte fields
`define SPIMM_HD_TXE_BIT 3
`define SPIMM_HD_RXF_BIT 2
`define SPIMM_HD_ACK_BIT 1

// Command byte layout
`define SPIMM_CMD_DIR_BIT 4

// Serial clock divider: half period in system clocks
`define SPIMM_HALF_DIV 8'h04
`define SPIMM_BITS 4'h8
`define SPIMM_LEG_SETUP 4'h3
`define SPIMM_ZERO8 8'h00

`endif

//--- core/spimm_pkg.sv
package spimm_pkg;
	typedef enum logic [1:0] {
		SPIMM_HD4 = 2'b00,
		SPIMM_HD3 = 2'b01,
		SPIMM_UNM = 2'b10,
		SPIMM_LEG = 2'b11
	} spimm_mode_e;

	// Pins towards the slave device
	typedef struct packed {
		logic sclk;
		logic sel;
		logic mosi_o;
		logic mosi_oe;
	} spimm_pins_s;
endpackage

//--- core/spimm_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
`include "spimm_defines.svh"
// ************************************************************
// Serial clock divider
// ************************************************************
module spimm_clkgen (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic run_i,
	// Strobes and serial clock
	output logic rise_o,
	output logic fall_o,
	output logic sclk_o
);
	logic [7:0] cnt_ff;
	logic sclk_ff;
	logic tick;

	assign tick = run_i && (cnt_ff == `SPIMM_HALF_DIV - 8'h01);
	assign rise_o = tick && !sclk_ff;
	assign fall_o = tick && sclk_ff;
	assign sclk_o = sclk_ff;

	// Clock idles low while stopped, so every frame starts on a rise
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_ff <= 8'h00;
			sclk_ff <= 1'b0;
		end else if (tick) begin
			cnt_ff <= 8'h00;
			sclk_ff <= !sclk_ff;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end
endmodule
`default_nettype wire

//--- test/spimm_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host port checker
// ****
module spimm_chk (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// Serial
	input wire spimm_pkg::spimm_pins_s pins_o
);
	import spimm_pkg::*;
	logic [1:0] mode_ff;
	logic [4:0] cnt_ff;
	logic sck_ff;
	// Mode mirror; select polarity depends on it
	wire leg = mode_ff == SPIMM_LEG;
	wire act = leg ? pins_o.sel : !pins_o.sel;
	wire rise = pins_o.sclk && !sck_ff;
	wire wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
		&& wb_adr_i == 4'h0;

	// Count serial rises inside a frame
	always_ff @(posedge clk_i) begin
		sck_ff <= pins_o.sclk;
		if (rst_i)
			mode_ff <= 2'h0;
		else if (wr_ctrl)
			mode_ff <= wb_dat_i[2:1];
		// A rise that meets the deselect still counts: the host drops
		// select on the edge that launches its last legacy clock
		if (rst_i || !act && !rise)
			cnt_ff <= 5'h00;
		else if (rise)
			cnt_ff <= cnt_ff + 5'h01;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("no ack one cycle after request");
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack longer than one cycle");
	property p_leg_sel;
		leg && rise |-> $past(pins_o.sel);
	endproperty
	a_leg_sel: assert property (p_leg_sel)
		else $error("select low at legacy clock rise");
	property p_leg_start;
		leg && rise && cnt_ff == 5'h00 |-> $past(pins_o.mosi_o);
	endproperty
	a_leg_start: assert property (p_leg_start)
		else $error("legacy start bit not one");
	property p_leg_launch;
		leg && $past(pins_o.sel) && cnt_ff != 5'h00 && cnt_ff < 5'h0C
			&& $changed(pins_o.mosi_o) |-> pins_o.sclk;
	endproperty
	a_leg_launch: assert property (p_leg_launch)
		else $error("legacy data moved off the rising edge");
	property p_leg_len;
		leg && $fell(pins_o.sel) && cnt_ff != 5'h00 |=> cnt_ff == 5'h0C;
	endproperty
	a_leg_len: assert property (p_leg_len)
		else $error("legacy frame not twelve clocks");
	property p_leg_gap;
		leg && $fell(pins_o.sel) && cnt_ff != 5'h00 |-> !pins_o.sel [*8];
	endproperty
	a_leg_gap: assert property (p_leg_gap)
		else $error("legacy select gap too short");
	property p_spi_sel;
		!leg && rise |-> !pins_o.sel;
	endproperty
	a_spi_sel: assert property (p_spi_sel)
		else $error("clock rise while deselected");
	property p_spi_launch;
		!leg && !pins_o.sel && !$past(pins_o.sel) && cnt_ff != 5'h00
			&& $changed(pins_o.mosi_o) |-> !pins_o.sclk;
	endproperty
	a_spi_launch: assert property (p_spi_launch)
		else $error("data moved while clock high");
endmodule

bind spimm_host spimm_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .pins_o);
`default_nettype wire

//--- test/spimm_dev.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Slave device model
// ****
module spimm_dev (
	// System
	input wire logic clk_i,
	// Serial
	input wire logic sclk_i,
	input wire logic sel_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic mosi_o,
	output logic mosi_oe_o,
	// Bench side
	input wire logic [1:0] mode_i,
	input wire logic full_i,
	input wire logic [7:0] tx_byte_i,
	output logic [7:0] rx_o
);
	import spimm_pkg::*;
	logic [8:0] out_ff;
	logic [10:0] in_ff;
	logic [4:0] cnt_ff;
	logic sck_ff;
	logic mosi_ff;
	logic stale_ff = 1'b0;
	logic drv_ff = 1'b0;
	logic hd_rd_ff = 1'b0;
	// Edges seen on the system clock; mosi_ff holds the pre-edge level
	wire leg = mode_i == SPIMM_LEG;
	wire unm = mode_i == SPIMM_UNM;
	wire hd3 = mode_i == SPIMM_HD3;
	wire act = leg ? sel_i : !sel_i;
	wire rise = sclk_i && !sck_ff;
	wire fall = !sclk_i && sck_ff;
	wire [7:0] leg_stat = {6'h0C, stale_ff, full_i};
	wire [7:0] hd_stat = {4'h0, stale_ff, full_i, 2'h2};
	wire [7:0] rd_byte = mosi_ff ? leg_stat : tx_byte_i;
	wire [8:0] load = in_ff[0] ? {rd_byte, stale_ff && !mosi_ff}
		: {8'hFF, full_i};
	assign miso_o = out_ff[8];
	assign mosi_o = out_ff[8];
	assign mosi_oe_o = drv_ff;
	initial rx_o = 8'h00;

	// Deselect drops the frame, so a half frame never lands
	always @(posedge clk_i) begin
		sck_ff <= sclk_i;
		mosi_ff <= mosi_i;
		if (!act) begin
			if (!leg && cnt_ff == (hd3 ? 5'h18 : unm ? 5'h08 : 5'h10))
				rx_o <= in_ff[7:0];
			cnt_ff <= 5'h00;
			drv_ff <= 1'b0;
			out_ff <= {unm ? tx_byte_i : hd_stat, 1'b1};
		end else if (rise) begin
			in_ff <= {in_ff[9:0], mosi_ff};
			cnt_ff <= cnt_ff + 5'h01;
			if (leg && cnt_ff == 5'h02) begin
				out_ff <= load;
				stale_ff <= stale_ff || in_ff[0] && !mosi_ff;
			end else if (leg && cnt_ff > 5'h02 && cnt_ff < 5'h0B)
				out_ff <= {out_ff[7:0], 1'b1};
			if (leg && cnt_ff == 5'h0A && in_ff[8:7] == 2'h0 && !full_i)
				rx_o <= {in_ff[6:0], mosi_ff};
		end else if (fall && !leg && cnt_ff != 5'h00) begin
			out_ff <= {out_ff[7:0], 1'b1};
			// Take the shared line only after the command's last fall
			if (!unm && cnt_ff == 5'h08 && (hd3 || in_ff[4])) begin
				hd_rd_ff <= in_ff[4];
				drv_ff <= 1'b1;
				out_ff <= {hd3 ? hd_stat : tx_byte_i, 1'b1};
			end
			// After the 3-pin status byte: keep driving only for reads
			if (hd3 && cnt_ff == 5'h10) begin
				drv_ff <= hd_rd_ff;
				out_ff <= {tx_byte_i, 1'b1};
			end
		end
	end
endmodule
`default_nettype wire

//--- test/test_spimm_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "spimm_defines.svh"
module test_spimm_host;
	import spimm_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [3:0] wb_adr = 4'h0;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic wb_ack;
	spimm_pins_s pins;
	logic miso;
	logic full = 1'b0;
	logic [1:0] dev_mode = 2'h0;
	logic [7:0] dev_tx = 8'h00;
	logic [7:0] dev_rx;
	logic [31:0] rd;
	logic flag;
	int mismatches = 0;
	int checks_done = 0;
	logic dev_mosi;
	logic dev_oe;
	// Released line shows the inverse so a stale level never passes
	wire logic mosi_line = pins.mosi_oe ? pins.mosi_o
		: (dev_oe ? dev_mosi : !pins.mosi_o);

	spimm_host dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .pins_o(pins), .mosi_i(mosi_line),
		.miso_i(miso));
	spimm_dev dev (.clk_i(clk_i), .sclk_i(pins.sclk), .sel_i(pins.sel),
		.mosi_i(mosi_line), .miso_o(miso), .mosi_o(dev_mosi),
		.mosi_oe_o(dev_oe), .mode_i(dev_mode),
		.full_i(full), .tx_byte_i(dev_tx), .rx_o(dev_rx));

	initial forever #20 clk_i = ~clk_i;

	// One classic cycle; the slave sets the pace
	task automatic wb_io(input logic we, input logic [3:0] adr,
		input logic [31:0] wd);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= wd;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (wb_ack !== 1'b1)
			mismatches++;
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// Control write without the go bit first so the idle select level settles
	task automatic frame(input logic [8:0] ctrl, input logic [7:0] txd);
		dev_mode <= ctrl[2:1];
		wb_io(1'b1, `SPIMM_REG_CTRL, {23'h0, ctrl & 9'h1FE});
		wb_io(1'b1, `SPIMM_REG_TXD, {24'h0, txd});
		wb_io(1'b1, `SPIMM_REG_CTRL, {23'h0, ctrl});
		do
			wb_io(1'b0, `SPIMM_REG_STAT, 32'h0);
		while (rd[1:0] !== 2'b10);
		flag = rd[2];
	endtask

	task automatic rx_read;
		wb_io(1'b0, `SPIMM_REG_RXD, 32'h0);
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp,
		input logic eflag);
		checks_done++;
		if ({flag, got} !== {eflag, exp}) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, {flag, got},
				{eflag, exp});
		end
	endtask

	task automatic complete_run;
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ****
	// Scenarios
	// ****
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		frame(9'h007, 8'hA5);
		check(dev_rx, 8'hA5, 1'b0);
		wb_io(1'b0, 4'h2, 32'h0);
		check(rd[7:0], 8'h00, 1'b0);
		full <= 1'b1;
		frame(9'h007, 8'h3C);
		check(dev_rx, 8'hA5, 1'b1);
		dev_tx <= 8'h96;
		frame(9'h00F, 8'h00);
		rx_read;
		check(rd[7:0], 8'h96, 1'b0);
		frame(9'h00F, 8'h00);
		rx_read;
		check(rd[7:0], 8'h96, 1'b1);
		frame(9'h01F, 8'h00);
		rx_read;
		check(rd[7:0], 8'h33, 1'b0);
		full <= 1'b0;
		dev_tx <= 8'h5A;
		frame(9'h005, 8'hC3);
		check(dev_rx, 8'hC3, 1'b0);
		rx_read;
		check(rd[7:0], 8'h5A, 1'b0);
		frame(9'h1A1, 8'h69);
		check(dev_rx, 8'h69, 1'b0);
		full <= 1'b1;
		frame(9'h1A1, 8'h11);
		check(dev_rx, 8'h69, 1'b1);
		full <= 1'b0;
		dev_tx <= 8'hE1;
		frame(9'h1A9, 8'h00);
		rx_read;
		check(rd[7:0], 8'hE1, 1'b0);
		frame(9'h1A3, 8'h4B);
		check(dev_rx, 8'h4B, 1'b0);
		wb_io(1'b0, `SPIMM_REG_STAT, 32'h0);
		check(rd[15:8], 8'h0A, 1'b0);
		dev_tx <= 8'h87;
		frame(9'h1AB, 8'h00);
		rx_read;
		check(rd[7:0], 8'h87, 1'b0);
		complete_run;
	end

	// Whole run needs a few thousand cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		complete_run;
	end
endmodule
`default_nettype wire
